// File: include/canopen_pkg.sv
/*
 * Shared constants for the fieldbus message server: identifier bases,
 * command specifier fields, abort codes, byte limits and timing.
 * Assumes an 11-bit identifier bus with byte k of a frame in bits 8k+7:8k.
 */
`default_nettype none

package canopen_pkg;

	// ------------------------------------------------------------
	// Clock and protocol timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned SDO_TIMEOUT_MS = 1000;
	localparam int unsigned SDO_TIMEOUT_CYC = (CLK_HZ / 1000) * SDO_TIMEOUT_MS;

	// ------------------------------------------------------------
	// Identifier bases, node number is added on top
	// ------------------------------------------------------------
	localparam logic [10:0] TPDO0_BASE = 11'h180;
	localparam logic [10:0] RPDO0_BASE = 11'h200;
	localparam logic [10:0] TPDO1_BASE = 11'h280;
	localparam logic [10:0] RPDO1_BASE = 11'h300;
	localparam logic [10:0] SDO_TX_BASE = 11'h580;
	localparam logic [10:0] SDO_RX_BASE = 11'h600;

	// ------------------------------------------------------------
	// Command specifier layout
	// ------------------------------------------------------------
	localparam logic [2:0] CCS_DL_SEG = 3'h0;
	localparam logic [2:0] CCS_DL_INIT = 3'h1;
	localparam logic [2:0] CCS_UL_INIT = 3'h2;
	localparam logic [2:0] CCS_UL_SEG = 3'h3;
	localparam logic [2:0] CS_ABORT = 3'h4;
	localparam logic [2:0] SCS_UL_SEG = 3'h0;
	localparam logic [2:0] SCS_DL_SEG = 3'h1;
	localparam logic [2:0] SCS_UL_INIT = 3'h2;
	localparam logic [2:0] SCS_DL_INIT = 3'h3;
	localparam int unsigned TOGGLE_BIT = 4;
	localparam int unsigned EXP_BIT = 1;
	localparam int unsigned SIZE_BIT = 0;
	localparam int unsigned LAST_BIT = 0;

	// ------------------------------------------------------------
	// Byte limits
	// ------------------------------------------------------------
	localparam logic [3:0] PDO_MAX_BYTES = 4'h8;
	localparam logic [2:0] EXP_MAX_BYTES = 3'h4;
	localparam logic [2:0] SEG_MAX_BYTES = 3'h7;
	localparam logic [3:0] SDO_DLC = 4'h8;

	// ------------------------------------------------------------
	// Abort codes
	// ------------------------------------------------------------
	localparam logic [31:0] ABORT_TOGGLE = 32'h05030000;
	localparam logic [31:0] ABORT_TIMEOUT = 32'h05040000;
	localparam logic [31:0] ABORT_BAD_CS = 32'h05040001;

	typedef enum logic [2:0] {
		OD_WRITE_EXP,
		OD_WRITE_OPEN,
		OD_WRITE_SEG,
		OD_READ_INIT,
		OD_READ_SEG
	} od_kind_t;

	function automatic logic [10:0] comm_object_identifier(input logic [10:0] base,
		input logic [6:0] node);
		return base + {4'h0, node};
	endfunction : comm_object_identifier

endpackage : canopen_pkg

`default_nettype wire

// File: hdl/frame_classifier.sv
/*
 * Sorts an incoming identifier into service data request or receive
 * process data object for this node.
 * Assumes the node number is stable while frames arrive.
 */
`timescale 1ns/1ps
`default_nettype none

module frame_classifier (
	// Frame identifier and node
	input wire logic [10:0] id_i,
	input wire logic [6:0] node_id_i,
	// Classification
	output logic is_sdo_o,
	output logic is_rpdo_o,
	output logic rpdo_sel_o
);
	import canopen_pkg::*;

	logic hit_rpdo0;
	logic hit_rpdo1;

	// Each object answers to exactly one identifier
	assign hit_rpdo0 = (id_i == comm_object_identifier(RPDO0_BASE, node_id_i));
	assign hit_rpdo1 = (id_i == comm_object_identifier(RPDO1_BASE, node_id_i));
	assign is_sdo_o = (id_i == comm_object_identifier(SDO_RX_BASE, node_id_i));
	assign is_rpdo_o = hit_rpdo0 | hit_rpdo1;
	assign rpdo_sel_o = hit_rpdo1;

endmodule : frame_classifier

`default_nettype wire

// File: hdl/sdo_timeout_timer.sv
/*
 * Watchdog for an open service data transfer.
 * Assumes kick_i pulses whenever the peer moves the protocol on.
 */
`timescale 1ns/1ps
`default_nettype none

module sdo_timeout_timer #(
	parameter int unsigned LIMIT = canopen_pkg::SDO_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Control
	input wire logic enable_i,
	input wire logic kick_i,
	// Event
	output logic expired_o
);
	logic [31:0] cnt_q;

	// Count restarts whenever idle or kicked, so only silence expires
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 32'h0;
			expired_o <= 1'b0;
		end else begin
			expired_o <= 1'b0;
			if (!enable_i || kick_i) begin
				cnt_q <= 32'h0;
			end else if (cnt_q == 32'(LIMIT - 1)) begin
				cnt_q <= 32'h0;
				expired_o <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 32'h1;
			end
		end
	end

endmodule : sdo_timeout_timer

`default_nettype wire

// File: hdl/canopen_sdo_pdo_server.sv
/*
 * Slave-side message server: two receive and two transmit process data
 * objects plus one service data server with expedited and segmented
 * transfers and aborts, toward an application dictionary port.
 * Assumes a CAN controller on the same clock that delivers one received
 * frame per rx_valid_i pulse and takes tx frames by valid/ready.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - One unique identifier selects each object
// - Process data frames carry at most eight bytes
// - Process data is identifier plus raw data
// - Transmit objects on event or sync, mixed
// - Receive and transmit objects kept apart
// - Process data outranks service data responses
// - Service frames carry specifier, index, subindex
// - Payloads above four bytes go segmented
// - Download segments only after initiate completes
// - Initiate upload answer carries short value
// - Upload segments only after initiate completes
// - Flags e and s decode payload field
// - Payload field is little-endian, bytes four-seven
// - Empty-byte count drops trailing segment bytes
// - Segment bytes pass through unchanged
// - Errors end transfer with abort frame
// - Abort code is one unsigned 32-bit value
// - Peer silence aborts with timeout code
module canopen_sdo_pdo_server #(
	parameter int unsigned TIMEOUT_CYC = canopen_pkg::SDO_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Configuration
	input wire logic [6:0] node_id_i,
	// Received frames
	input wire logic rx_valid_i,
	input wire logic [10:0] rx_id_i,
	input wire logic [3:0] rx_dlc_i,
	input wire logic [63:0] rx_data_i,
	// Transmitted frames
	output logic tx_valid_o,
	input wire logic tx_ready_i,
	output logic [10:0] tx_id_o,
	output logic [3:0] tx_dlc_o,
	output logic [63:0] tx_data_o,
	// Receive process data
	output logic rpdo_valid_o,
	output logic rpdo_sel_o,
	output logic [3:0] rpdo_len_o,
	output logic [63:0] rpdo_data_o,
	// Transmit process data
	input wire logic sync_i,
	input wire logic [1:0] tpdo_sync_mode_i,
	input wire logic [1:0] tpdo_event_i,
	input wire logic [1:0][3:0] tpdo_len_i,
	input wire logic [1:0][63:0] tpdo_data_i,
	// Dictionary access
	output logic od_req_o,
	output canopen_pkg::od_kind_t od_kind_o,
	output logic [15:0] od_index_o,
	output logic [7:0] od_subindex_o,
	output logic [55:0] od_wdata_o,
	output logic [2:0] od_count_o,
	output logic od_last_o,
	output logic [31:0] od_size_o,
	input wire logic od_ack_i,
	input wire logic od_error_i,
	input wire logic [31:0] od_error_code_i,
	input wire logic [55:0] od_rdata_i,
	input wire logic [31:0] od_rsize_i,
	// Status
	output logic sdo_busy_o,
	output logic sdo_abort_o,
	output logic [31:0] abort_code_o
);
	import canopen_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [55:0] keep_bytes(input logic [55:0] d,
		input logic [2:0] n);
		logic [55:0] m;
		m = 56'h0;
		for (int i = 0; i < 7; i++) begin
			if (3'(i) < n) begin
				m[8*i +: 8] = d[8*i +: 8];
			end
		end
		return m;
	endfunction : keep_bytes

	function automatic logic [3:0] clip_len(input logic [3:0] n);
		return (n > PDO_MAX_BYTES) ? PDO_MAX_BYTES : n;
	endfunction : clip_len

	// Byte 0 specifier, bytes 1-2 index, byte 3 subindex, 4-7 payload
	function automatic logic [63:0] sdo_frame(input logic [7:0] cs,
		input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] pay);
		return {pay, sub, idx, cs};
	endfunction : sdo_frame

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DL_WAIT,
		ST_DL_OPEN,
		ST_UL_WAIT,
		ST_UL_OPEN
	} sdo_state_t;

	// ------------------------------------------------------------
	// Frame sorting and watchdog
	// ------------------------------------------------------------
	logic is_sdo;
	logic is_rpdo;
	logic rpdo_sel;
	logic timer_expired;
	sdo_state_t state_q;
	logic resp_valid_q;
	logic [63:0] resp_data_q;
	logic toggle_q;
	logic [31:0] remain_q;
	logic sdo_take;
	logic resp_taken;
	logic [1:0] tpdo_pend_q;
	logic tx_free;

	frame_classifier u_classifier (
		.id_i(rx_id_i),
		.node_id_i(node_id_i),
		.is_sdo_o(is_sdo),
		.is_rpdo_o(is_rpdo),
		.rpdo_sel_o(rpdo_sel)
	);

	// Time runs only while the peer owes us the next step
	sdo_timeout_timer #(
		.LIMIT(TIMEOUT_CYC)
	) u_timer (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.enable_i((state_q == ST_DL_OPEN || state_q == ST_UL_OPEN)
			&& !resp_valid_q),
		.kick_i(sdo_take),
		.expired_o(timer_expired)
	);

	// ------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------
	logic [7:0] rx_cs;
	logic [2:0] rx_ccs;
	logic [15:0] rx_index;
	logic [7:0] rx_sub;
	logic [31:0] rx_pay;
	logic [2:0] rx_exp_count;
	logic [2:0] rx_seg_count;
	logic [2:0] rd_seg_count;
	logic rd_seg_last;
	logic [55:0] rd_exp_bytes;

	assign rx_cs = rx_data_i[7:0];
	assign rx_ccs = rx_cs[7:5];
	assign rx_index = rx_data_i[23:8];
	assign rx_sub = rx_data_i[31:24];
	assign rx_pay = rx_data_i[63:32];
	// Expedited size given only with s set, else the full field
	assign rx_exp_count = rx_cs[SIZE_BIT]
		? (EXP_MAX_BYTES - {1'b0, rx_cs[3:2]})
		: EXP_MAX_BYTES;
	assign rx_seg_count = SEG_MAX_BYTES - rx_cs[3:1];
	assign rd_seg_last = (remain_q <= 32'(SEG_MAX_BYTES));
	assign rd_seg_count = rd_seg_last ? remain_q[2:0] : SEG_MAX_BYTES;
	assign rd_exp_bytes = keep_bytes(od_rdata_i, od_rsize_i[2:0]);

	// Frames arriving while the dictionary works are dropped
	assign sdo_take = rx_valid_i && is_sdo && !resp_valid_q
		&& (state_q != ST_DL_WAIT) && (state_q != ST_UL_WAIT);

	// ------------------------------------------------------------
	// Service data server
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			toggle_q <= 1'b0;
			remain_q <= 32'h0;
			resp_valid_q <= 1'b0;
			resp_data_q <= 64'h0;
			od_req_o <= 1'b0;
			od_kind_o <= OD_WRITE_EXP;
			od_index_o <= 16'h0;
			od_subindex_o <= 8'h0;
			od_wdata_o <= 56'h0;
			od_count_o <= 3'h0;
			od_last_o <= 1'b0;
			od_size_o <= 32'h0;
			sdo_abort_o <= 1'b0;
			abort_code_o <= 32'h0;
		end else begin
			sdo_abort_o <= 1'b0;
			if (resp_taken) begin
				resp_valid_q <= 1'b0;
			end
			if (timer_expired) begin
				resp_valid_q <= 1'b1;
				resp_data_q <= sdo_frame({CS_ABORT, 5'h0}, od_index_o,
					od_subindex_o, ABORT_TIMEOUT);
				abort_code_o <= ABORT_TIMEOUT;
				od_req_o <= 1'b0;
				state_q <= ST_IDLE;
			end else if (od_req_o) begin
				if (od_ack_i) begin
					od_req_o <= 1'b0;
					resp_valid_q <= 1'b1;
					if (od_error_i) begin
						resp_data_q <= sdo_frame({CS_ABORT, 5'h0}, od_index_o,
							od_subindex_o, od_error_code_i);
						abort_code_o <= od_error_code_i;
						state_q <= ST_IDLE;
					end else begin
						case (od_kind_o)
							OD_WRITE_EXP: begin
								resp_data_q <= sdo_frame({SCS_DL_INIT, 5'h0},
									od_index_o, od_subindex_o, 32'h0);
								state_q <= ST_IDLE;
							end
							OD_WRITE_OPEN: begin
								resp_data_q <= sdo_frame({SCS_DL_INIT, 5'h0},
									od_index_o, od_subindex_o, 32'h0);
								toggle_q <= 1'b0;
								state_q <= ST_DL_OPEN;
							end
							OD_WRITE_SEG: begin
								resp_data_q <= sdo_frame({SCS_DL_SEG, toggle_q,
									4'h0}, 16'h0, 8'h0, 32'h0);
								toggle_q <= !toggle_q;
								state_q <= od_last_o ? ST_IDLE : ST_DL_OPEN;
							end
							OD_READ_INIT: begin
								if ((od_rsize_i != 32'h0)
									&& (od_rsize_i <= 32'(EXP_MAX_BYTES))) begin
									resp_data_q <= sdo_frame({SCS_UL_INIT, 1'b0,
										2'(EXP_MAX_BYTES - od_rsize_i[2:0]),
										2'b11}, od_index_o, od_subindex_o,
										rd_exp_bytes[31:0]);
									state_q <= ST_IDLE;
								end else begin
									// Size announced, data follows in segments
									resp_data_q <= sdo_frame({SCS_UL_INIT, 4'h0,
										1'b1}, od_index_o, od_subindex_o,
										od_rsize_i);
									remain_q <= od_rsize_i;
									toggle_q <= 1'b0;
									state_q <= ST_UL_OPEN;
								end
							end
							OD_READ_SEG: begin
								resp_data_q <= {keep_bytes(od_rdata_i,
									rd_seg_count), SCS_UL_SEG, toggle_q,
									SEG_MAX_BYTES - rd_seg_count,
									rd_seg_last};
								remain_q <= remain_q - {29'h0, rd_seg_count};
								toggle_q <= !toggle_q;
								state_q <= rd_seg_last ? ST_IDLE : ST_UL_OPEN;
							end
							default: begin
								state_q <= ST_IDLE;
							end
						endcase
					end
				end
			end else if (sdo_take) begin
				case (rx_ccs)
					CCS_DL_INIT: begin
						od_index_o <= rx_index;
						od_subindex_o <= rx_sub;
						od_req_o <= 1'b1;
						od_last_o <= 1'b1;
						state_q <= ST_DL_WAIT;
						if (rx_cs[EXP_BIT]) begin
							od_kind_o <= OD_WRITE_EXP;
							od_wdata_o <= keep_bytes({24'h0, rx_pay},
								rx_exp_count);
							od_count_o <= rx_exp_count;
							od_size_o <= {29'h0, rx_exp_count};
						end else begin
							od_kind_o <= OD_WRITE_OPEN;
							od_wdata_o <= 56'h0;
							od_count_o <= 3'h0;
							// Reserved field is not trusted when s is clear
							od_size_o <= rx_cs[SIZE_BIT] ? rx_pay : 32'h0;
						end
					end
					CCS_UL_INIT: begin
						od_index_o <= rx_index;
						od_subindex_o <= rx_sub;
						od_kind_o <= OD_READ_INIT;
						od_req_o <= 1'b1;
						state_q <= ST_UL_WAIT;
					end
					CCS_DL_SEG: begin
						if (state_q != ST_DL_OPEN) begin
							resp_valid_q <= 1'b1;
							resp_data_q <= sdo_frame({CS_ABORT, 5'h0}, od_index_o,
								od_subindex_o, ABORT_BAD_CS);
							abort_code_o <= ABORT_BAD_CS;
							state_q <= ST_IDLE;
						end else if (rx_cs[TOGGLE_BIT] != toggle_q) begin
							resp_valid_q <= 1'b1;
							resp_data_q <= sdo_frame({CS_ABORT, 5'h0}, od_index_o,
								od_subindex_o, ABORT_TOGGLE);
							abort_code_o <= ABORT_TOGGLE;
							state_q <= ST_IDLE;
						end else begin
							od_kind_o <= OD_WRITE_SEG;
							od_wdata_o <= keep_bytes(rx_data_i[63:8],
								rx_seg_count);
							od_count_o <= rx_seg_count;
							od_last_o <= rx_cs[LAST_BIT];
							od_req_o <= 1'b1;
							state_q <= ST_DL_WAIT;
						end
					end
					CCS_UL_SEG: begin
						if (state_q != ST_UL_OPEN) begin
							resp_valid_q <= 1'b1;
							resp_data_q <= sdo_frame({CS_ABORT, 5'h0}, od_index_o,
								od_subindex_o, ABORT_BAD_CS);
							abort_code_o <= ABORT_BAD_CS;
							state_q <= ST_IDLE;
						end else if (rx_cs[TOGGLE_BIT] != toggle_q) begin
							resp_valid_q <= 1'b1;
							resp_data_q <= sdo_frame({CS_ABORT, 5'h0}, od_index_o,
								od_subindex_o, ABORT_TOGGLE);
							abort_code_o <= ABORT_TOGGLE;
							state_q <= ST_IDLE;
						end else begin
							od_kind_o <= OD_READ_SEG;
							od_count_o <= rd_seg_count;
							od_req_o <= 1'b1;
							state_q <= ST_UL_WAIT;
						end
					end
					CS_ABORT: begin
						// Master abort is never answered
						sdo_abort_o <= 1'b1;
						abort_code_o <= rx_pay;
						state_q <= ST_IDLE;
					end
					default: begin
						resp_valid_q <= 1'b1;
						resp_data_q <= sdo_frame({CS_ABORT, 5'h0}, rx_index,
							rx_sub, ABORT_BAD_CS);
						abort_code_o <= ABORT_BAD_CS;
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	assign sdo_busy_o = (state_q != ST_IDLE);

	// ------------------------------------------------------------
	// Receive process data
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rpdo_valid_o <= 1'b0;
			rpdo_sel_o <= 1'b0;
			rpdo_len_o <= 4'h0;
			rpdo_data_o <= 64'h0;
		end else begin
			rpdo_valid_o <= rx_valid_i && is_rpdo;
			if (rx_valid_i && is_rpdo) begin
				rpdo_sel_o <= rpdo_sel;
				rpdo_len_o <= clip_len(rx_dlc_i);
				rpdo_data_o <= rx_data_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit process data triggers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tpdo_pend_q <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				// A trigger in the sending cycle stays pending
				if (tpdo_sync_mode_i[i] ? sync_i : tpdo_event_i[i]) begin
					tpdo_pend_q[i] <= 1'b1;
				end else if (tx_free && (i == 0 || !tpdo_pend_q[0])) begin
					tpdo_pend_q[i] <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit arbitration
	// ------------------------------------------------------------
	assign tx_free = !tx_valid_o || tx_ready_i;
	assign resp_taken = tx_free && (tpdo_pend_q == 2'b00) && resp_valid_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_valid_o <= 1'b0;
			tx_id_o <= 11'h0;
			tx_dlc_o <= 4'h0;
			tx_data_o <= 64'h0;
		end else if (tx_free) begin
			// Process data first, service answers wait behind it
			if (tpdo_pend_q[0]) begin
				tx_valid_o <= 1'b1;
				tx_id_o <= comm_object_identifier(TPDO0_BASE, node_id_i);
				tx_dlc_o <= clip_len(tpdo_len_i[0]);
				tx_data_o <= tpdo_data_i[0];
			end else if (tpdo_pend_q[1]) begin
				tx_valid_o <= 1'b1;
				tx_id_o <= comm_object_identifier(TPDO1_BASE, node_id_i);
				tx_dlc_o <= clip_len(tpdo_len_i[1]);
				tx_data_o <= tpdo_data_i[1];
			end else if (resp_valid_q) begin
				tx_valid_o <= 1'b1;
				tx_id_o <= comm_object_identifier(SDO_TX_BASE, node_id_i);
				tx_dlc_o <= SDO_DLC;
				tx_data_o <= resp_data_q;
			end else begin
				tx_valid_o <= 1'b0;
			end
		end
	end

endmodule : canopen_sdo_pdo_server

`default_nettype wire

// File: testbench/server_chk.sv
/* Port checker for the message server.
 Assumes it is bound onto canopen_sdo_pdo_server. */
`timescale 1ns/1ps
`default_nettype none
module server_chk (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Frames
	input wire logic [6:0] node_id_i,
	input wire logic rx_valid_i,
	input wire logic [10:0] rx_id_i,
	input wire logic [63:0] rx_data_i,
	input wire logic tx_valid_o,
	input wire logic tx_ready_i,
	input wire logic [10:0] tx_id_o,
	input wire logic [3:0] tx_dlc_o,
	input wire logic [63:0] tx_data_o,
	input wire logic rpdo_valid_o,
	input wire logic rpdo_sel_o,
	input wire logic [63:0] rpdo_data_o,
	// Dictionary and status
	input wire logic od_req_o,
	input wire canopen_pkg::od_kind_t od_kind_o,
	input wire logic [15:0] od_index_o,
	input wire logic od_ack_i,
	input wire logic sdo_busy_o,
	input wire logic sdo_abort_o,
	input wire logic [31:0] abort_code_o
);
	import canopen_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence rx_rpdo0;
		rx_valid_i && rx_id_i == RPDO0_BASE + {4'h0, node_id_i};
	endsequence
	// Checked only for an idle server with nothing queued taking a new initiate
	sequence rx_exp_write;
		rx_valid_i && rx_id_i == SDO_RX_BASE + {4'h0, node_id_i} &&
		rx_data_i[7:5] == CCS_DL_INIT && rx_data_i[1] &&
		!sdo_busy_o && !tx_valid_o && !od_req_o &&
		!$past(sdo_busy_o) && !$past(rx_valid_i);
	endsequence
	chk_rpdo_deliver: assert property (rx_rpdo0 |=> rpdo_valid_o &&
		!rpdo_sel_o && rpdo_data_o == $past(rx_data_i))
		else $error("receive object not delivered raw");
	chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
		tx_valid_o && $stable(tx_data_o) && $stable(tx_id_o))
		else $error("frame changed before ready");
	chk_tx_dlc: assert property (tx_valid_o |-> tx_dlc_o <= 4'h8)
		else $error("frame longer than eight bytes");
	chk_od_hold: assert property (od_req_o && !od_ack_i |=>
		od_req_o && $stable(od_index_o) && $stable(od_kind_o))
		else $error("dictionary request not held");
	chk_od_release: assert property (od_req_o && od_ack_i |=> !od_req_o)
		else $error("dictionary request not dropped");
	chk_abort_pulse: assert property (sdo_abort_o |=> !sdo_abort_o)
		else $error("abort flag longer than one cycle");
	chk_abort_code: assert property (tx_valid_o && tx_data_o[7:0] == 8'h80
		&& tx_id_o == SDO_TX_BASE + {4'h0, node_id_i}
		|-> tx_data_o[63:32] == abort_code_o)
		else $error("abort frame code differs from status");
	chk_exp_write: assert property (rx_exp_write |=> od_req_o &&
		od_kind_o == OD_WRITE_EXP && od_index_o == $past(rx_data_i[23:8]))
		else $error("expedited write not forwarded");
endmodule : server_chk
bind canopen_sdo_pdo_server server_chk chk (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .node_id_i(node_id_i), .rx_valid_i(rx_valid_i),
	.rx_id_i(rx_id_i), .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o),
	.tx_ready_i(tx_ready_i), .tx_id_o(tx_id_o), .tx_dlc_o(tx_dlc_o),
	.tx_data_o(tx_data_o), .rpdo_valid_o(rpdo_valid_o),
	.rpdo_sel_o(rpdo_sel_o), .rpdo_data_o(rpdo_data_o),
	.od_req_o(od_req_o), .od_kind_o(od_kind_o), .od_index_o(od_index_o),
	.od_ack_i(od_ack_i), .sdo_busy_o(sdo_busy_o),
	.sdo_abort_o(sdo_abort_o), .abort_code_o(abort_code_o));
`default_nettype wire

// File: testbench/can_master_model.sv
/* Bus master model: takes transmitted frames, stalling at random.
 Assumes the server clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module can_master_model (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Frames from the server
	input wire logic stall_i,
	input wire logic tx_valid_i,
	input wire logic [10:0] tx_id_i,
	input wire logic [63:0] tx_data_i,
	output logic ready_o,
	// Last frame taken
	output logic got_o,
	output logic [10:0] got_id_o,
	output logic [63:0] got_data_o
);
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ready_o <= 1'b0;
			got_o <= 1'b0;
			got_id_o <= 11'h000;
			got_data_o <= 64'h0;
		end else begin
			ready_o <= !stall_i || ($urandom_range(1) == 1);
			got_o <= tx_valid_i && ready_o;
			if (tx_valid_i && ready_o) begin
				got_id_o <= tx_id_i;
				got_data_o <= tx_data_i;
			end
		end
	end
endmodule : can_master_model
`default_nettype wire

// File: testbench/canopen_sdo_pdo_server_test.sv
/* Self-checking bench for the message server.
 Assumes server_chk is bound and the master model takes frames. */
`timescale 1ns/1ps
`default_nettype none
module canopen_sdo_pdo_server_test;
	import canopen_pkg::*;
	logic ref_clk_i, rst_i, rx_valid_i, tx_ready_i, sync_i, stall;
	logic od_ack_i, od_error_i, got, tx_valid_o, od_req_o, sdo_abort_o;
	logic [6:0] node_id_i;
	logic [10:0] rx_id_i, got_id, tx_id_o;
	logic [3:0] rx_dlc_i, rpdo_len_o, tx_dlc_o;
	logic [63:0] rx_data_i, got_data, tx_data_o, rpdo_data_o, d, d2;
	logic rpdo_valid_o, rpdo_sel_o, sdo_busy_o, od_last_o;
	logic [1:0] tpdo_sync_mode_i, tpdo_event_i;
	logic [1:0][3:0] tpdo_len_i;
	logic [1:0][63:0] tpdo_data_i;
	od_kind_t od_kind_o;
	logic [15:0] od_index_o, idx;
	logic [7:0] od_subindex_o, sub;
	logic [55:0] od_wdata_o, od_rdata_i;
	logic [2:0] od_count_o;
	logic [31:0] od_error_code_i, od_rsize_i, abort_code_o, x, od_size_o;
	int fails, tests_run, k;
	logic s;
	logic [3:0] n;
	canopen_sdo_pdo_server #(.TIMEOUT_CYC(50)) dut (.*);
	can_master_model master (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.stall_i(stall), .tx_valid_i(tx_valid_o), .tx_id_i(tx_id_o),
		.tx_data_i(tx_data_o), .ready_o(tx_ready_i), .got_o(got),
		.got_id_o(got_id), .got_data_o(got_data));
	initial begin
		ref_clk_i = 0;
		forever #25 ref_clk_i = !ref_clk_i;
	end
	function automatic logic [10:0] idf(input logic [10:0] b);
		return b + {4'h0, node_id_i};
	endfunction : idf
	task end_of_test;
		if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	task chk(input logic [63:0] g, input logic [63:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("mismatch %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task tick;
		@(posedge ref_clk_i);
		#1;
	endtask : tick
	task send(input logic [10:0] id, input logic [63:0] v);
		tick;
		rx_valid_i = 1;
		rx_id_i = id;
		rx_dlc_i = n;
		rx_data_i = v;
		tick;
		rx_valid_i = 0;
	endtask : send
	task serve(input logic e, input logic [55:0] rd, input logic [31:0] rs);
		int i;
		i = 0;
		while (od_req_o !== 1'b1 && i < 100) begin
			tick;
			i++;
		end
		chk(od_req_o, 1);
		od_ack_i = 1;
		od_error_i = e;
		od_rdata_i = rd;
		od_rsize_i = rs;
		tick;
		od_ack_i = 0;
		od_error_i = 0;
	endtask : serve
	task frame(input logic [10:0] id, input logic [63:0] e, input logic [63:0] m);
		int i;
		i = 0;
		do begin
			tick;
			i++;
		end while (got !== 1'b1 && i < 300);
		chk(got, 1);
		chk({53'h0, got_id}, {53'h0, id});
		chk(got_data & m, e & m);
	endtask : frame
	task sdo(input logic [7:0] cs, input logic [31:0] pay);
		send(idf(SDO_RX_BASE), {pay, sub, idx, cs});
	endtask : sdo
	initial begin
		#(50 * 20000);
		fails++;
		end_of_test;
	end
	initial begin
		{rx_valid_i, sync_i, od_ack_i, od_error_i, stall} = 0;
		{rx_id_i, rx_dlc_i, rx_data_i, tpdo_event_i, od_rdata_i} = 0;
		{tpdo_sync_mode_i, tpdo_len_i, tpdo_data_i, od_error_code_i} = 0;
		{od_rsize_i, fails, tests_run} = 0;
		x = $urandom(34);
		node_id_i = 7'h01 + 7'($urandom % 127);
		n = 4'h8;
		rst_i = 1;
		repeat (20) @(posedge ref_clk_i);
		#1 rst_i = 0;
		for (k = 0; k < 8; k++) begin
			s = 1'($urandom);
			n = 4'($urandom);
			d = {$urandom, $urandom};
			send(idf(s ? RPDO1_BASE : RPDO0_BASE), d);
			chk(rpdo_valid_o, 1);
			chk(rpdo_sel_o, s);
			chk(rpdo_len_o, n > 8 ? 8 : n);
			chk(rpdo_data_o, d);
		end
		send(idf(TPDO0_BASE), d);
		chk(rpdo_valid_o, 0);
		stall = 1;
		{d, d2} = {$urandom, $urandom, $urandom, $urandom};
		tpdo_sync_mode_i = 2'b01;
		tpdo_len_i = {4'h8, 4'h3};
		tpdo_data_i = {d, d2};
		tpdo_event_i = 2'b10;
		tick;
		tpdo_event_i = 0;
		frame(idf(TPDO1_BASE), d, '1);
		sync_i = 1;
		tick;
		sync_i = 0;
		frame(idf(TPDO0_BASE), d2, 64'hffffff);
		{x, idx, sub} = {$urandom, 24'($urandom)};
		od_error_code_i = 32'h06020000;
		sdo(8'h23, x);
		chk(od_kind_o, OD_WRITE_EXP);
		chk({od_subindex_o, od_index_o}, {sub, idx});
		chk({od_count_o, od_wdata_o[31:0]}, {3'h4, x});
		chk({od_last_o, od_size_o}, {1'b1, 32'd4});
		serve(0, 0, 0);
		frame(idf(SDO_TX_BASE), {32'h0, sub, idx, 8'h60}, '1);
		sdo(8'h23, x);
		serve(1, 0, 0);
		frame(idf(SDO_TX_BASE), {32'h06020000, sub, idx, 8'h80}, '1);
		sdo(8'h21, 32'd9);
		chk({od_kind_o, od_size_o}, {OD_WRITE_OPEN, 32'd9});
		serve(0, 0, 0);
		frame(idf(SDO_TX_BASE), {32'h0, sub, idx, 8'h60}, '1);
		send(idf(SDO_RX_BASE), {d[55:0], 8'h00});
		chk({od_count_o, od_wdata_o}, {3'h7, d[55:0]});
		serve(0, 0, 0);
		frame(idf(SDO_TX_BASE), {56'h0, 8'h20}, '1);
		send(idf(SDO_RX_BASE), {d[55:0], 8'h1b});
		chk({od_last_o, od_count_o, od_wdata_o}, {4'ha, 40'h0, d[15:0]});
		serve(0, 0, 0);
		frame(idf(SDO_TX_BASE), {56'h0, 8'h30}, '1);
		d = {$urandom, $urandom};
		sdo(8'h40, 0);
		chk(od_kind_o, OD_READ_INIT);
		serve(0, d[55:0], 2);
		frame(idf(SDO_TX_BASE), {d[31:0], sub, idx, 8'h4b}, 64'hffff_ffffffff);
		sdo(8'h40, 0);
		serve(0, d[55:0], 10);
		frame(idf(SDO_TX_BASE), {32'd10, sub, idx, 8'h41}, '1);
		sdo(8'h60, 0);
		chk({od_kind_o, od_count_o}, {OD_READ_SEG, 3'h7});
		serve(0, d[55:0], 0);
		frame(idf(SDO_TX_BASE), {d[55:0], 8'h00}, '1);
		sdo(8'h70, 0);
		serve(0, d[55:0], 0);
		frame(idf(SDO_TX_BASE), {40'h0, d[23:0], 8'h19}, '1);
		sdo(8'h00, 0);
		frame(idf(SDO_TX_BASE), {ABORT_BAD_CS, 32'h80}, 64'hffffffff_000000ff);
		sdo(8'h80, x);
		chk({sdo_abort_o, abort_code_o}, {1'b1, x});
		sdo(8'h40, 0);
		serve(0, d[55:0], 20);
		frame(idf(SDO_TX_BASE), {32'd20, sub, idx, 8'h41}, '1);
		sdo(8'h70, 0);
		frame(idf(SDO_TX_BASE), {ABORT_TOGGLE, sub, idx, 8'h80}, '1);
		sdo(8'h40, 0);
		serve(0, d[55:0], 20);
		frame(idf(SDO_TX_BASE), {32'd20, sub, idx, 8'h41}, '1);
		frame(idf(SDO_TX_BASE), {ABORT_TIMEOUT, sub, idx, 8'h80}, '1);
		chk(sdo_busy_o, 0);
		end_of_test;
	end
endmodule : canopen_sdo_pdo_server_test
`default_nettype wire
